/* File: rtl/otp_cfg_pkg.sv */
// Constants for the one-time-programmable configuration store.
// Assumes a single 10 MHz system clock and host access from on-chip logic.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package otp_cfg_pkg;
	localparam logic [15:0] ADDR_HARDWARE_CONFIG_LOCK = 16'h0000;
	localparam logic [15:0] ADDR_OVERRIDE = 16'h0007;
	localparam logic [15:0] ADDR_FLOW = 16'h0008;
	localparam logic [15:0] ADDR_PIN_MODE = 16'h0009;
	localparam logic [15:0] ADDR_DIR_LOW = 16'h000B;
	localparam logic [15:0] ADDR_DIR_HIGH = 16'h000C;
	localparam logic [15:0] ADDR_MASK_LOW = 16'h000D;
	localparam logic [15:0] ADDR_MASK_HIGH = 16'h000E;
	localparam logic [15:0] ADDR_THRESH_0 = 16'h000F;
	localparam logic [15:0] ADDR_THRESH_1 = 16'h0010;
	localparam logic [15:0] ADDR_THRESH_2 = 16'h0011;
	localparam logic [15:0] ADDR_PROG_LOW = 16'h001D;
	localparam logic [15:0] ADDR_PROG_HIGH = 16'h001E;
	localparam logic [15:0] ADDR_LOCK_ARM = 16'h1898;
	localparam logic [7:0] LOCK_ARM_VALUE = 8'h10;
	localparam int STORE_DEPTH = 32;
	// Program-select bit positions in the low program byte.
	localparam int PS_HARDWARE_CONFIG_LOCK = 0;
	localparam int PS_OVERRIDE = 1;
	localparam int PS_FLOW = 2;
	localparam int PS_PIN_MODE = 3;
	localparam int PS_DIR = 4;
	localparam int PS_MASK = 5;
	localparam int PS_THRESH = 6;
	localparam int PS_NONE = 8;
	localparam int HW_LOCK_BIT = 6;
	localparam int OV_THRESH_BIT = 4;
	localparam int OV_MASK_BIT = 3;
	localparam int OV_DIR_BIT = 2;
	localparam int OV_PIN_BIT = 1;
	localparam int OV_FLOW_BIT = 0;
	localparam int FLOW_HALF_DUPLEX_BIT = 3;
	localparam int PIN_CLK_EN_BIT = 7;
	localparam int PIN_DED_EN_BIT = 4;
	localparam int PIN_POL_BIT = 3;
	localparam logic [2:0] FLOW_NONE = 3'h0;
	localparam logic [2:0] FLOW_HW = 3'h1;
	localparam logic [2:0] FLOW_SW = 3'h2;
	localparam logic [2:0] FLOW_MATCH_RX = 3'h3;
	localparam logic [2:0] FLOW_MATCH_ALL = 3'h4;
	localparam logic [1:0] DED_GPIO = 2'h0;
	localparam logic [1:0] DED_ON_TX = 2'h1;
	localparam logic [1:0] DED_ON_MATCH = 2'h2;
	localparam logic [2:0] REQ_GPIO = 3'h0;
	localparam logic [2:0] REQ_RTS_CTS = 3'h1;
	localparam logic [2:0] REQ_DTR_DSR = 3'h2;
	localparam logic [2:0] REQ_EN_TX = 3'h3;
	localparam logic [2:0] REQ_EN_MATCH = 3'h4;
	localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

/* File: rtl/otp_config_overrides.sv */
// Configuration store with per-field program lock, global lock and the
// override word that chooses stored or built-in serial settings.
// Assumes host access and UART status come from logic on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none
module otp_config_overrides #(
	parameter logic [23:0] DEFAULT_THRESH = 24'h00_0000,
	parameter logic [10:0] DEFAULT_INT_MASK = 11'h000,
	parameter logic [9:0] DEFAULT_DIR = 10'h000,
	parameter logic [7:0] DEFAULT_PIN_MODE = 8'h00,
	parameter logic [7:0] DEFAULT_FLOW = 8'h00
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic store_erase_i,
	input wire logic [15:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic uart_tx_busy_i,
	input wire logic uart_rx_valid_i,
	input wire logic addr_match_i,
	output logic [7:0] host_rdata_o,
	output logic host_rvalid_o,
	output logic host_wr_refused_o,
	output logic lock_active_o,
	output logic [23:0] rate_threshold_o,
	output logic [10:0] gpio_int_mask_o,
	output logic [9:0] gpio_dir_o,
	output logic hw_flow_en_o,
	output logic sw_flow_en_o,
	output logic rx_accept_o,
	output logic tx_allowed_o,
	output logic clock_out_pin_en_o,
	output logic dedicated_enable_pin_auto_o,
	output logic dedicated_enable_pin_o,
	output logic request_pin_shared_auto_o,
	output logic request_pin_shared_o,
	output logic handshake_rts_cts_o,
	output logic handshake_dtr_dsr_o
);
	// ------------------------------------------------------------------
	// Store and host access
	// ------------------------------------------------------------------
	// The byte array models fuse cells: it survives reset and is only
	// blanked by store_erase_i, which stands for a fresh part.
	logic [7:0] store_q [0:otp_cfg_pkg::STORE_DEPTH-1];
	logic [7:0] lock_arm_q;
	logic lock_active_q;
	logic load_pending_q;
	logic [7:0] host_rdata_q;
	logic host_rvalid_q;
	logic host_wr_refused_q;

	function automatic int field_of(input logic [15:0] a);
		int f;
		f = otp_cfg_pkg::PS_NONE;
		case (a)
			otp_cfg_pkg::ADDR_HARDWARE_CONFIG_LOCK: f = otp_cfg_pkg::PS_HARDWARE_CONFIG_LOCK;
			otp_cfg_pkg::ADDR_OVERRIDE: f = otp_cfg_pkg::PS_OVERRIDE;
			otp_cfg_pkg::ADDR_FLOW: f = otp_cfg_pkg::PS_FLOW;
			otp_cfg_pkg::ADDR_PIN_MODE: f = otp_cfg_pkg::PS_PIN_MODE;
			otp_cfg_pkg::ADDR_DIR_LOW: f = otp_cfg_pkg::PS_DIR;
			otp_cfg_pkg::ADDR_DIR_HIGH: f = otp_cfg_pkg::PS_DIR;
			otp_cfg_pkg::ADDR_MASK_LOW: f = otp_cfg_pkg::PS_MASK;
			otp_cfg_pkg::ADDR_MASK_HIGH: f = otp_cfg_pkg::PS_MASK;
			otp_cfg_pkg::ADDR_THRESH_0: f = otp_cfg_pkg::PS_THRESH;
			otp_cfg_pkg::ADDR_THRESH_1: f = otp_cfg_pkg::PS_THRESH;
			otp_cfg_pkg::ADDR_THRESH_2: f = otp_cfg_pkg::PS_THRESH;
			default: f = otp_cfg_pkg::PS_NONE;
		endcase
		return f;
	endfunction

	wire [4:0] store_idx = host_addr_i[4:0];
	wire in_store = (host_addr_i[15:5] == 11'h000);
	wire is_prog_byte = (host_addr_i == otp_cfg_pkg::ADDR_PROG_LOW) ||
		(host_addr_i == otp_cfg_pkg::ADDR_PROG_HIGH);
	wire is_arm = (host_addr_i == otp_cfg_pkg::ADDR_LOCK_ARM);
	wire [7:0] prog_low = store_q[otp_cfg_pkg::ADDR_PROG_LOW[4:0]];
	wire [7:0] hw_byte = store_q[otp_cfg_pkg::ADDR_HARDWARE_CONFIG_LOCK[4:0]];
	wire field_mapped = (field_of(host_addr_i) != otp_cfg_pkg::PS_NONE);
	wire mapped = in_store && (field_mapped || is_prog_byte);
	wire field_sealed = field_mapped &&
		prog_low[field_of(host_addr_i) % 8];
	// The lock bit only sticks once the arm register holds its key.
	wire lock_key_ok = (lock_arm_q == otp_cfg_pkg::LOCK_ARM_VALUE);
	wire lock_try = (host_addr_i == otp_cfg_pkg::ADDR_HARDWARE_CONFIG_LOCK) &&
		host_wdata_i[otp_cfg_pkg::HW_LOCK_BIT] && !lock_key_ok;
	wire [7:0] lock_strip = lock_try ?
		~(8'h01 << otp_cfg_pkg::HW_LOCK_BIT) : 8'hFF;
	// The arm register sits outside the store, so the global lock never
	// refuses it and a host can always load the key again.
	wire wr_ok = host_wr_i && mapped && !lock_active_q &&
		!field_sealed;
	wire wr_refused = host_wr_i && !is_arm && !wr_ok;
	// Fuses only go from 0 to 1, so a write ORs into the cell and a field
	// sealed without data stays all zeros.
	wire [7:0] store_wr_value = store_q[store_idx] |
		(host_wdata_i & lock_strip);
	wire [7:0] rd_value = !mapped ? 8'h00 : store_q[store_idx];

	// A held write strobe writes once per cycle; since cells only OR, a
	// repeat of the same byte is harmless.
	always_ff @(posedge clk_sys_i)
	begin
		for (int i = 0; i < otp_cfg_pkg::STORE_DEPTH; i++)
		begin
			if (store_erase_i)
				store_q[i] <= otp_cfg_pkg::RESET_BYTE;
			else if (wr_ok && (store_idx == 5'(i)))
				store_q[i] <= store_wr_value;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			lock_arm_q <= otp_cfg_pkg::RESET_BYTE;
			host_rdata_q <= otp_cfg_pkg::RESET_BYTE;
			host_rvalid_q <= 1'b0;
			host_wr_refused_q <= 1'b0;
		end
		else
		begin
			if (host_wr_i && is_arm)
				lock_arm_q <= host_wdata_i;
			host_rdata_q <= host_rd_i ? (is_arm ? lock_arm_q : rd_value) :
				host_rdata_q;
			host_rvalid_q <= host_rd_i;
			host_wr_refused_q <= wr_refused;
		end
	end

	// ------------------------------------------------------------------
	// Load after reset
	// ------------------------------------------------------------------
	// Settings are sampled once, in the first cycle after reset release,
	// so a lock or override programmed now waits for the next reset.
	// A write taken in the load cycle is still judged against the old,
	// cleared lock, so hosts should wait one more cycle after reset.
	wire [7:0] ov_byte = store_q[otp_cfg_pkg::ADDR_OVERRIDE[4:0]];
	wire [23:0] stored_thresh = {store_q[otp_cfg_pkg::ADDR_THRESH_2[4:0]],
		store_q[otp_cfg_pkg::ADDR_THRESH_1[4:0]],
		store_q[otp_cfg_pkg::ADDR_THRESH_0[4:0]]};
	wire [10:0] stored_mask = {store_q[otp_cfg_pkg::ADDR_MASK_HIGH[4:0]][2:0],
		store_q[otp_cfg_pkg::ADDR_MASK_LOW[4:0]]};
	wire [9:0] stored_dir = {store_q[otp_cfg_pkg::ADDR_DIR_HIGH[4:0]][1:0],
		store_q[otp_cfg_pkg::ADDR_DIR_LOW[4:0]]};
	wire lock_load = hw_byte[otp_cfg_pkg::HW_LOCK_BIT] &&
		prog_low[otp_cfg_pkg::PS_HARDWARE_CONFIG_LOCK];
	wire [23:0] thresh_load = ov_byte[otp_cfg_pkg::OV_THRESH_BIT] ?
		stored_thresh : DEFAULT_THRESH;
	wire [10:0] mask_load = ov_byte[otp_cfg_pkg::OV_MASK_BIT] ?
		stored_mask : DEFAULT_INT_MASK;
	wire [9:0] dir_load = ov_byte[otp_cfg_pkg::OV_DIR_BIT] ?
		stored_dir : DEFAULT_DIR;
	wire [7:0] pin_load = ov_byte[otp_cfg_pkg::OV_PIN_BIT] ?
		store_q[otp_cfg_pkg::ADDR_PIN_MODE[4:0]] : DEFAULT_PIN_MODE;
	wire [7:0] flow_load = ov_byte[otp_cfg_pkg::OV_FLOW_BIT] ?
		store_q[otp_cfg_pkg::ADDR_FLOW[4:0]] : DEFAULT_FLOW;

	logic [23:0] rate_threshold_q;
	logic [10:0] gpio_int_mask_q;
	logic [9:0] gpio_dir_q;
	logic [7:0] pin_mode_q;
	logic [7:0] flow_q;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			load_pending_q <= 1'b1;
			lock_active_q <= 1'b0;
			rate_threshold_q <= 24'h00_0000;
			gpio_int_mask_q <= 11'h000;
			gpio_dir_q <= 10'h000;
			pin_mode_q <= otp_cfg_pkg::RESET_BYTE;
			flow_q <= otp_cfg_pkg::RESET_BYTE;
		end
		else if (load_pending_q)
		begin
			load_pending_q <= 1'b0;
			lock_active_q <= lock_load;
			rate_threshold_q <= thresh_load;
			gpio_int_mask_q <= mask_load;
			gpio_dir_q <= dir_load;
			pin_mode_q <= pin_load;
			flow_q <= flow_load;
		end
	end

	// ------------------------------------------------------------------
	// Serial behaviour from the applied settings
	// ------------------------------------------------------------------
	// Reserved flow codes fall back to plain operation.
	// Reserved dedicated code 11 and request codes 101 to 111 leave their
	// pins as general I/O, which is the safe state for a transceiver.
	// Inversion applies only in the automatic modes, so a pin left as
	// general I/O never idles at the inverted level.
	wire [2:0] flow_mode = flow_q[2:0];
	wire half_duplex = flow_q[otp_cfg_pkg::FLOW_HALF_DUPLEX_BIT];
	wire mode_hw = (flow_mode == otp_cfg_pkg::FLOW_HW);
	wire mode_sw = (flow_mode == otp_cfg_pkg::FLOW_SW);
	wire mode_match_rx = (flow_mode == otp_cfg_pkg::FLOW_MATCH_RX);
	wire mode_match_all = (flow_mode == otp_cfg_pkg::FLOW_MATCH_ALL);
	wire rx_gated_match = (mode_match_rx || mode_match_all) &&
		!addr_match_i;
	wire rx_gated_duplex = half_duplex && uart_tx_busy_i;
	wire rx_accept_d = uart_rx_valid_i && !rx_gated_match &&
		!rx_gated_duplex;
	wire tx_allowed_d = !mode_match_all || addr_match_i;

	wire [1:0] ded_sel = pin_mode_q[6:5];
	wire ded_pin_on = pin_mode_q[otp_cfg_pkg::PIN_DED_EN_BIT];
	wire [2:0] req_sel = pin_mode_q[2:0];
	wire invert_en = pin_mode_q[otp_cfg_pkg::PIN_POL_BIT];
	wire ded_auto_tx = ded_pin_on && (ded_sel == otp_cfg_pkg::DED_ON_TX);
	wire ded_auto_match = ded_pin_on &&
		(ded_sel == otp_cfg_pkg::DED_ON_MATCH);
	wire ded_level = (ded_auto_tx && uart_tx_busy_i) ||
		(ded_auto_match && addr_match_i);
	wire req_auto_tx = (req_sel == otp_cfg_pkg::REQ_EN_TX);
	wire req_auto_match = (req_sel == otp_cfg_pkg::REQ_EN_MATCH);
	wire req_level = (req_auto_tx && uart_tx_busy_i) ||
		(req_auto_match && addr_match_i);

	logic rx_accept_q;
	logic tx_allowed_q;
	logic ded_auto_q;
	logic ded_pin_q;
	logic req_auto_q;
	logic req_pin_q;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rx_accept_q <= 1'b0;
			tx_allowed_q <= 1'b0;
			ded_auto_q <= 1'b0;
			ded_pin_q <= 1'b0;
			req_auto_q <= 1'b0;
			req_pin_q <= 1'b0;
		end
		else
		begin
			rx_accept_q <= rx_accept_d;
			tx_allowed_q <= tx_allowed_d;
			ded_auto_q <= ded_auto_tx || ded_auto_match;
			ded_pin_q <= ded_level ^ (invert_en &&
				(ded_auto_tx || ded_auto_match));
			req_auto_q <= req_auto_tx || req_auto_match;
			req_pin_q <= req_level ^ (invert_en &&
				(req_auto_tx || req_auto_match));
		end
	end

	logic hw_flow_q;
	logic sw_flow_q;
	logic clk_out_q;
	logic rts_cts_q;
	logic dtr_dsr_q;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			hw_flow_q <= 1'b0;
			sw_flow_q <= 1'b0;
			clk_out_q <= 1'b0;
			rts_cts_q <= 1'b0;
			dtr_dsr_q <= 1'b0;
		end
		else
		begin
			hw_flow_q <= mode_hw;
			sw_flow_q <= mode_sw;
			clk_out_q <= pin_mode_q[otp_cfg_pkg::PIN_CLK_EN_BIT];
			rts_cts_q <= (req_sel == otp_cfg_pkg::REQ_RTS_CTS);
			dtr_dsr_q <= (req_sel == otp_cfg_pkg::REQ_DTR_DSR);
		end
	end

	assign host_rdata_o = host_rdata_q;
	assign host_rvalid_o = host_rvalid_q;
	assign host_wr_refused_o = host_wr_refused_q;
	assign lock_active_o = lock_active_q;
	assign rate_threshold_o = rate_threshold_q;
	assign gpio_int_mask_o = gpio_int_mask_q;
	assign gpio_dir_o = gpio_dir_q;
	assign hw_flow_en_o = hw_flow_q;
	assign sw_flow_en_o = sw_flow_q;
	assign rx_accept_o = rx_accept_q;
	assign tx_allowed_o = tx_allowed_q;
	assign clock_out_pin_en_o = clk_out_q;
	assign dedicated_enable_pin_auto_o = ded_auto_q;
	assign dedicated_enable_pin_o = ded_pin_q;
	assign request_pin_shared_auto_o = req_auto_q;
	assign request_pin_shared_o = req_pin_q;
	assign handshake_rts_cts_o = rts_cts_q;
	assign handshake_dtr_dsr_o = dtr_dsr_q;
endmodule
`default_nettype wire

/* File: testbench/otp_config_overrides_chk.sv */
// Concurrent checks on the ports of the configuration store.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module otp_config_overrides_chk (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [15:0] host_addr_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic uart_rx_valid_i,
	input wire logic addr_match_i,
	input wire logic host_rvalid_o,
	input wire logic host_wr_refused_o,
	input wire logic lock_active_o,
	input wire logic hw_flow_en_o,
	input wire logic sw_flow_en_o,
	input wire logic rx_accept_o,
	input wire logic tx_allowed_o,
	input wire logic dedicated_enable_pin_auto_o,
	input wire logic dedicated_enable_pin_o,
	input wire logic request_pin_shared_auto_o,
	input wire logic handshake_rts_cts_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	// The lock is loaded once after reset, so it is only judged once the
	// load cycle and the first settled cycle have gone by.
	logic [1:0] up_q;
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
		if (!reset_n_i)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_read_answer:
		assert property (host_rd_i |=> host_rvalid_o)
		else $error("read request not answered");
	a_no_stray_read:
		assert property (!host_rd_i |=> !host_rvalid_o)
		else $error("read answer without request");
	a_lock_refuse:
		assert property (lock_active_o && host_wr_i &&
			host_addr_i != otp_cfg_pkg::ADDR_LOCK_ARM |=> host_wr_refused_o)
		else $error("write accepted under global lock");
	a_lock_steady:
		assert property (up_q == 2'h3 |-> $stable(lock_active_o))
		else $error("lock changed without a reset");
	a_rx_needs_valid:
		assert property (!uart_rx_valid_i |=> !rx_accept_o)
		else $error("receive accepted without valid data");
	a_tx_on_match:
		assert property (addr_match_i |=> tx_allowed_o)
		else $error("transmit blocked despite address match");
	a_flow_one_kind:
		assert property (!(hw_flow_en_o && sw_flow_en_o))
		else $error("hardware and software flow both on");
	a_ded_gpio_idle:
		assert property (!dedicated_enable_pin_auto_o |->
			!dedicated_enable_pin_o)
		else $error("dedicated pin driven while general I/O");
	a_handshake_one:
		assert property (handshake_rts_cts_o |-> !request_pin_shared_auto_o)
		else $error("request pin has two functions");
endmodule
bind otp_config_overrides otp_config_overrides_chk i_otp_config_overrides_chk (.*);
`default_nettype wire

/* File: testbench/otp_config_overrides_tb.sv */
// Self-checking bench for the configuration store and its overrides.
// Assumes the checker is bound in and the host model owns the host port.
`timescale 1ns/1ns
`default_nettype none
module otp_config_overrides_tb;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	// The store starts blank: the erase is held through the first reset.
	logic store_erase_i = 1'b1;
	logic uart_tx_busy_i = 1'b0;
	logic uart_rx_valid_i = 1'b0;
	logic addr_match_i = 1'b0;
	logic [15:0] host_addr_i;
	logic [7:0] host_wdata_i, host_rdata_o;
	logic host_wr_i, host_rd_i, host_rvalid_o, host_wr_refused_o;
	logic lock_active_o, hw_flow_en_o, sw_flow_en_o, rx_accept_o;
	logic tx_allowed_o, clock_out_pin_en_o, handshake_rts_cts_o;
	logic dedicated_enable_pin_auto_o, dedicated_enable_pin_o;
	logic request_pin_shared_auto_o, request_pin_shared_o;
	logic handshake_dtr_dsr_o;
	logic [23:0] rate_threshold_o;
	logic [10:0] gpio_int_mask_o;
	logic [9:0] gpio_dir_o;
	logic [7:0] vals [7] = '{8'hC5, 8'h02, 8'h5A, 8'h05, 8'h11, 8'h22, 8'h33};
	logic [7:0] pins [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h06, 8'h07, 8'h10, 8'h30, 8'h50, 8'h70, 8'h0C};
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	otp_config_overrides i_otp_config_overrides (.*);
	otp_host_model i_otp_host_model (.clk_sys_i(clk_sys_i),
		.rdata_i(host_rdata_o), .refused_i(host_wr_refused_o),
		.addr_o(host_addr_i), .wdata_o(host_wdata_i),
		.wr_o(host_wr_i), .rd_o(host_rd_i));
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic restart;
		@(posedge clk_sys_i);
		#10 reset_n_i = 1'b0;
		repeat (8) @(posedge clk_sys_i);
		#10 reset_n_i = 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#10;
	endtask
	task automatic uart(input logic t, input logic v, input logic m);
		@(posedge clk_sys_i);
		#10 uart_tx_busy_i = t;
		uart_rx_valid_i = v;
		addr_match_i = m;
		@(posedge clk_sys_i);
		#10;
	endtask
	// Blank part, then flow, pin mode and override bytes, then a reset.
	task automatic cfg(input logic [7:0] ov, input logic [7:0] fl,
		input logic [7:0] pm);
		logic r;
		@(posedge clk_sys_i);
		#10 store_erase_i = 1'b1;
		@(posedge clk_sys_i);
		#10 store_erase_i = 1'b0;
		restart();
		i_otp_host_model.wr(16'h0008, fl, r);
		i_otp_host_model.wr(16'h0009, pm, r);
		i_otp_host_model.wr(16'h0007, ov, r);
		restart();
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_blank;
		logic [7:0] d;
		logic r;
		cfg(8'h00, 8'h00, 8'h00);
		i_otp_host_model.rd(16'h0000, d);
		chk(d, 8'h00);
		i_otp_host_model.rd(16'h001D, d);
		chk(d, 8'h00);
		i_otp_host_model.wr(16'h000A, 8'h5A, r);
		chk(r, 1'b1);
		i_otp_host_model.rd(16'h000A, d);
		chk(d, 8'h00);
		chk(lock_active_o, 1'b0);
		$display("blank store test done");
	endtask
	task automatic t_override;
		logic r;
		cfg(8'h00, 8'h09, 8'hB9);
		for (int i = 0; i < 7; i++)
			i_otp_host_model.wr(16'h000B + 16'(i), vals[i], r);
		restart();
		chk(rate_threshold_o, 24'h00_0000);
		chk(gpio_int_mask_o, 11'h000);
		chk(gpio_dir_o, 10'h000);
		chk(clock_out_pin_en_o, 1'b0);
		chk(hw_flow_en_o, 1'b0);
		i_otp_host_model.wr(16'h0007, 8'h1F, r);
		restart();
		chk(rate_threshold_o, 24'h33_2211);
		chk(gpio_int_mask_o, 11'h55A);
		chk(gpio_dir_o, 10'h2C5);
		chk(clock_out_pin_en_o, 1'b1);
		chk(handshake_rts_cts_o, 1'b1);
		chk(hw_flow_en_o, 1'b1);
		uart(1'b1, 1'b1, 1'b0);
		chk(rx_accept_o, 1'b0);
		chk(dedicated_enable_pin_o, 1'b0);
		uart(1'b0, 1'b1, 1'b0);
		chk(rx_accept_o, 1'b1);
		chk(dedicated_enable_pin_o, 1'b1);
		$display("override test done");
	endtask
	task automatic t_modes;
		for (int m = 0; m < 8; m++)
		begin
			cfg(8'h03, 8'(m), 8'h01);
			uart(1'b0, 1'b1, 1'b0);
			chk(hw_flow_en_o, m == 1);
			chk(sw_flow_en_o, m == 2);
			chk(rx_accept_o, !(m == 3 || m == 4));
			chk(tx_allowed_o, m != 4);
		end
		for (int i = 0; i < 13; i++)
		begin
			cfg(8'h02, 8'h00, pins[i]);
			uart(1'b1, 1'b0, 1'b1);
			chk(handshake_rts_cts_o, i == 1);
			chk(handshake_dtr_dsr_o, i == 2);
			chk(request_pin_shared_auto_o, i inside {3, 4, 12});
			chk(request_pin_shared_o, i == 3 || i == 4);
			chk(dedicated_enable_pin_auto_o, i == 9 || i == 10);
			chk(dedicated_enable_pin_o, i == 9 || i == 10);
		end
		$display("mode table test done");
	endtask
	task automatic t_prog;
		logic [7:0] d;
		logic r;
		cfg(8'h04, 8'h00, 8'h00);
		i_otp_host_model.wr(16'h001D, 8'h10, r);
		i_otp_host_model.wr(16'h000B, 8'hFF, r);
		chk(r, 1'b1);
		i_otp_host_model.wr(16'h000F, 8'hAB, r);
		i_otp_host_model.wr(16'h001D, 8'h40, r);
		i_otp_host_model.wr(16'h000F, 8'h54, r);
		chk(r, 1'b1);
		i_otp_host_model.rd(16'h000F, d);
		chk(d, 8'hAB);
		restart();
		chk(gpio_dir_o, 10'h000);
		i_otp_host_model.rd(16'h000B, d);
		chk(d, 8'h00);
		$display("program select test done");
	endtask
	task automatic t_lock;
		logic [7:0] d;
		logic r;
		cfg(8'h00, 8'h00, 8'h00);
		i_otp_host_model.wr(16'h0000, 8'h40, r);
		i_otp_host_model.rd(16'h0000, d);
		chk(d, 8'h00);
		i_otp_host_model.lock();
		i_otp_host_model.rd(16'h0000, d);
		chk(d, 8'h40);
		restart();
		chk(lock_active_o, 1'b0);
		i_otp_host_model.wr(16'h001D, 8'h01, r);
		i_otp_host_model.wr(16'h0010, 8'h01, r);
		chk(r, 1'b0);
		chk(lock_active_o, 1'b0);
		restart();
		chk(lock_active_o, 1'b1);
		i_otp_host_model.wr(16'h0011, 8'h0F, r);
		chk(r, 1'b1);
		i_otp_host_model.rd(16'h0011, d);
		chk(d, 8'h00);
		$display("global lock test done");
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys_i);
		#10 reset_n_i = 1'b1;
		store_erase_i = 1'b0;
		t_blank();
		t_override();
		t_modes();
		t_prog();
		t_lock();
		give_verdict();
	end
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			fail_count++;
			give_verdict();
		end
	end
endmodule
`default_nettype wire

/* File: testbench/otp_host_model.sv */
// Host model that programs and reads the store one byte at a time.
// Assumes the store takes requests on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module otp_host_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	input wire logic refused_i,
	output logic [15:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial
	begin
		addr_o = 16'h0000;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// A released bus shows inverted values so stale data is never trusted.
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		output logic r);
		@(posedge clk_sys_i);
		#10 addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clk_sys_i);
		#10 wr_o = 1'b0;
		r = refused_i;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		#10 addr_o = a;
		rd_o = 1'b1;
		@(posedge clk_sys_i);
		#10 rd_o = 1'b0;
		d = rdata_i;
		addr_o = ~a;
	endtask
	task automatic lock;
		logic r;
		wr(otp_cfg_pkg::ADDR_LOCK_ARM, otp_cfg_pkg::LOCK_ARM_VALUE, r);
		wr(otp_cfg_pkg::ADDR_HARDWARE_CONFIG_LOCK, 8'h40, r);
	endtask
endmodule
`default_nettype wire
